// [core/hdlc_aux_command_handler.sv]
// auxiliary command handler: pin write/read, error counter read, live mode and table update
// assumes counters come in from the datapath on the same clock, pins from outside
`timescale 1ns/100ps
module hdlc_aux_command_handler import aux_cmd_pkg::*; #(
  parameter int SAMPLE_PERIOD = SAMPLE_CYCLES
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire command_word_type command_word_in,
  output logic command_ready_out,
  output status_word_type status_word_out,
  input wire logic status_ready_in,
  input wire logic gp_input_one_in,
  input wire logic gp_input_two_in,
  output logic gp_output_one_out,
  output logic gp_output_two_out,
  input wire logic [NUM_STATS*16-1:0] stats_counters_in,
  input wire logic addr_check_in,
  input wire logic [7:0] rx_addr_first_in,
  input wire logic [7:0] rx_addr_second_in,
  input wire logic [15:0] rx_frame_length_in,
  output mode_type mode_out,
  output logic address_match_out,
  output logic short_frame_out
);
  handler_state_type cur;
  handler_state_type next_cur;
  logic status_busy;
  logic sel_all;
  logic hit;
  logic [3:0] short_len;
  logic [7:0] entry;
  logic [7:0] entry_pair_a;
  logic [7:0] entry_pair_b;
  logic [7:0] compare_byte;

  assign status_busy = cur.status.valid && !status_ready_in;
  // new command only when no answer is waiting and no dump runs
  assign command_ready_out = (cur.state == IDLE) && !status_busy;
  assign sel_all = (command_word_in.byte3 == SEL_ALL);

  // ----------------------------------------
  // address matching and short frames
  // ----------------------------------------
  always_comb begin
    hit = 1'b0;
    entry = ZERO_BYTE;
    entry_pair_a = ZERO_BYTE;
    entry_pair_b = ZERO_BYTE;
    compare_byte = (cur.mode.address_match == MATCH_SECOND) ? rx_addr_second_in
                                                             : rx_addr_first_in;
    for (int i = 0; i < TABLE_SIZE; i++) begin
      entry = cur.mode.address_table_entries[i*8 +: 8];
      if ((cur.mode.address_match == MATCH_FIRST || cur.mode.address_match == MATCH_SECOND)
          && i < int'(cur.mode.address_entry_count) && entry == compare_byte) begin
        hit = 1'b1; // RL13
      end
    end
    for (int j = 0; j < TABLE_SIZE / 2; j++) begin
      entry_pair_a = cur.mode.address_table_entries[(2*j)*8 +: 8];
      entry_pair_b = cur.mode.address_table_entries[(2*j+1)*8 +: 8];
      if (cur.mode.address_match == MATCH_BOTH && 2*j+1 < int'(cur.mode.address_entry_count)
          && entry_pair_a == rx_addr_first_in && entry_pair_b == rx_addr_second_in) begin
        hit = 1'b1; // RL14
      end
    end
    if (cur.mode.address_match == MATCH_NONE) begin
      hit = 1'b1; // RL9
    end
    case (cur.mode.short_select) // RL10
      SHORT_TWO: short_len = LEN_TWO;
      SHORT_THREE: short_len = LEN_THREE;
      default: short_len = LEN_FOUR;
    endcase
  end

  // ----------------------------------------
  // command interpreter
  // ----------------------------------------
  always_comb begin
    next_cur = cur;
    next_cur.sync1 = {gp_input_two_in, gp_input_one_in};
    next_cur.sync2 = cur.sync1;
    if (addr_check_in) begin
      next_cur.address_match_hit = hit;
      // frame length excludes the check sequence
      next_cur.short_flag = (rx_frame_length_in < {12'h000, short_len});
    end
    // levels reported to the host are the periodic snapshot
    if (cur.tick >= 32'(SAMPLE_PERIOD - 1)) begin
      next_cur.tick = '0;
      next_cur.in_sample = cur.sync2; // RL3
      next_cur.out_sample = cur.gp_output; // RL3
    end else begin
      next_cur.tick = cur.tick + 32'h1;
    end
    if (cur.status.valid && status_ready_in) begin
      next_cur.status.valid = 1'b0;
    end
    case (cur.state)
      IDLE: begin
        if (command_word_in.valid && command_ready_out) begin
          next_cur.status = '0;
          next_cur.status.valid = 1'b1;
          case (command_word_in.code)
            CMD_OUT_WRITE: begin
              next_cur.status.valid = 1'b0;
              next_cur.gp_output = {command_word_in.byte2[2], command_word_in.byte2[0]}; // RL1
            end
            CMD_PIN_READ: begin
              next_cur.status.code = STS_PIN_ACK; // RL2
              next_cur.status.pins = {4'h0, cur.out_sample, cur.in_sample};
            end
            CMD_PIN_READ_ALT: begin
              if (command_word_in.byte1 == ZERO_BYTE) begin
                next_cur.status.code = STS_PIN_ACK_ALT; // RL4
                next_cur.status.pins = {4'h0, cur.out_sample, cur.in_sample};
              end else begin
                next_cur.status.code = STS_ILLEGAL;
              end
            end
            CMD_STATS_READ_ALT: begin
              next_cur.status.code = STS_STATS_ACK; // RL8
              if (sel_all) begin
                next_cur.status.index = ZERO_BYTE; // RL6
                next_cur.status.value = stats_counters_in[15:0];
                next_cur.state = DUMP;
                next_cur.dump_index = 8'h01;
              end else if (command_word_in.byte2 < 8'(NUM_STATS)) begin
                next_cur.status.index = command_word_in.byte2; // RL7
                next_cur.status.value = stats_counters_in[command_word_in.byte2*16 +: 16];
              end else begin
                next_cur.status.code = STS_ILLEGAL;
              end
            end
            CMD_MODE_UPDATE: begin
              next_cur.status.valid = 1'b0;
              // only these fields move; everything else stays as it was
              next_cur.mode.address_match = command_word_in.byte2[1:0]; // RL11
              next_cur.mode.short_select = command_word_in.byte2[3:2];
              next_cur.mode.input_change_report_select = command_word_in.byte2[5:4];
            end
            CMD_ADDR_UPDATE: begin
              next_cur.status.valid = 1'b0;
              next_cur.mode.address_entry_count = command_word_in.entry_count; // RL11
              next_cur.mode.address_table_entries = command_word_in.entries;
            end
            default: next_cur.status.code = STS_ILLEGAL;
          endcase
        end
      end
      DUMP: begin
        if (!status_busy) begin
          next_cur.status.valid = 1'b1;
          next_cur.status.code = STS_STATS_ACK;
          next_cur.status.index = cur.dump_index; // RL6
          next_cur.status.value = stats_counters_in[cur.dump_index*16 +: 16];
          next_cur.dump_index = cur.dump_index + 8'h01;
          if (cur.dump_index == 8'(NUM_STATS - 1)) begin
            next_cur.state = IDLE;
          end
        end
      end
      default: next_cur.state = IDLE;
    endcase
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      cur <= '0;
      cur.gp_output <= OUT_RESET; // RL1
      cur.out_sample <= OUT_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  assign status_word_out = cur.status;
  assign gp_output_one_out = cur.gp_output[0];
  assign gp_output_two_out = cur.gp_output[1];
  assign mode_out = cur.mode;
  assign address_match_out = cur.address_match_hit;
  assign short_frame_out = cur.short_flag;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_out_write;
    @(posedge clk_in) disable iff (reset_in)
    command_word_in.valid && command_ready_out && command_word_in.code == CMD_OUT_WRITE
    |=> gp_output_one_out == $past(command_word_in.byte2[0])
        && gp_output_two_out == $past(command_word_in.byte2[2]);
  endproperty
  a_out_write: assert property (p_out_write) else $error("output pin mismatch"); // RL1
  property p_pin_read;
    @(posedge clk_in) disable iff (reset_in)
    command_word_in.valid && command_ready_out && command_word_in.code == CMD_PIN_READ
    |=> status_word_out.valid && status_word_out.code == STS_PIN_ACK;
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("no pin read ack"); // RL2
  property p_sample_hold;
    @(posedge clk_in) disable iff (reset_in)
    cur.tick < 32'(SAMPLE_PERIOD - 1) |=> $stable(cur.in_sample);
  endproperty
  a_sample_hold: assert property (p_sample_hold) else $error("sample moved early"); // RL3
  property p_sample_take;
    @(posedge clk_in) disable iff (reset_in)
    cur.tick == 32'(SAMPLE_PERIOD - 1) |=> cur.in_sample == $past(cur.sync2);
  endproperty
  a_sample_take: assert property (p_sample_take) else $error("sample not taken"); // RL3
  property p_pin_read_alt;
    @(posedge clk_in) disable iff (reset_in)
    command_word_in.valid && command_ready_out && command_word_in.code == CMD_PIN_READ_ALT
    && command_word_in.byte1 == ZERO_BYTE |=> status_word_out.code == STS_PIN_ACK_ALT;
  endproperty
  a_pin_read_alt: assert property (p_pin_read_alt) else $error("no alt pin ack"); // RL4
  sequence s_dump_start;
    command_word_in.valid && command_ready_out && command_word_in.code == CMD_STATS_READ_ALT
    && command_word_in.byte3 == SEL_ALL;
  endsequence
  property p_dump_all;
    @(posedge clk_in) disable iff (reset_in)
    s_dump_start |=> cur.state == DUMP && status_word_out.index == 8'h00;
  endproperty
  a_dump_all: assert property (p_dump_all) else $error("dump not started"); // RL6
  property p_stats_ack;
    @(posedge clk_in) disable iff (reset_in)
    status_word_out.valid && cur.state == DUMP |-> status_word_out.code == STS_STATS_ACK;
  endproperty
  a_stats_ack: assert property (p_stats_ack) else $error("wrong stats status"); // RL8
  property p_no_match_mode;
    @(posedge clk_in) disable iff (reset_in)
    addr_check_in && cur.mode.address_match == MATCH_NONE |=> address_match_out;
  endproperty
  a_no_match_mode: assert property (p_no_match_mode) else $error("match off rejected"); // RL9
  property p_short;
    @(posedge clk_in) disable iff (reset_in)
    addr_check_in && cur.mode.short_select == SHORT_TWO && rx_frame_length_in == 16'h0001
    |=> short_frame_out;
  endproperty
  a_short: assert property (p_short) else $error("short frame missed"); // RL10
  property p_mode_keep;
    @(posedge clk_in) disable iff (reset_in)
    command_word_in.valid && command_ready_out && command_word_in.code == CMD_MODE_UPDATE
    |=> $stable(cur.mode.address_entry_count) && $stable(cur.gp_output);
  endproperty
  a_mode_keep: assert property (p_mode_keep) else $error("mode update disturbed state"); // RL11
endmodule : hdlc_aux_command_handler

// [core/aux_cmd_pkg.sv]
// constants and carrier types for the auxiliary command handler
// assumes one 25 MHz core clock and a host that hands over whole command words
// Function
// RL1: output pins follow written bits; both come out of reset high
// RL2: code 42H answers with pin-read status holding both inputs and outputs
// RL3: reported pin levels come from sampling every 8 ms
// RL4: code 45H with zero second byte answers with second pin-read status
// RL5: host puts wanted counter number in the selector bytes of code 44H
// RL6: upper selector FFH returns every counter instead of one
// RL7: counter numbers 00H to 0AH map to the eleven error kinds
// RL8: code 44H answers with second statistics status; all counters are errors
// RL9: address-match field: none, first byte, second byte, both bytes
// RL10: short-frame field flags frames under 2, 3 or 4 bytes, check excluded
// RL11: mode and address-table updates accepted while line open, nothing else changed
// RL12: host loads the address table whenever matching is enabled
// RL13: single-byte modes compare one byte to each entry up to the count
// RL14: two-byte mode compares first two bytes against consecutive entry pairs
// RL15: host gives an even count of 2 to 12 for two-byte matching
// RL16: host stores FFH in a table entry to accept broadcast frames
package aux_cmd_pkg;
  // ----------------------------------------
  // command and status codes
  // ----------------------------------------
  localparam logic [7:0] CMD_OUT_WRITE = 8'h41;
  localparam logic [7:0] CMD_PIN_READ = 8'h42;
  localparam logic [7:0] CMD_STATS_READ_ALT = 8'h44;
  localparam logic [7:0] CMD_PIN_READ_ALT = 8'h45;
  localparam logic [7:0] CMD_MODE_UPDATE = 8'h46;
  localparam logic [7:0] CMD_ADDR_UPDATE = 8'h47;
  localparam logic [7:0] STS_PIN_ACK = 8'h42;
  localparam logic [7:0] STS_STATS_ACK = 8'h44;
  localparam logic [7:0] STS_PIN_ACK_ALT = 8'h45;
  localparam logic [7:0] STS_ILLEGAL = 8'h3F;
  localparam logic [7:0] SEL_ALL = 8'hFF;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam int NUM_STATS = 11;
  localparam int TABLE_SIZE = 12;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int SAMPLE_MS = 8;
  localparam int SAMPLE_CYCLES = CLK_HZ / 1000 * SAMPLE_MS;
  // ----------------------------------------
  // field encodings
  // ----------------------------------------
  localparam logic [1:0] MATCH_NONE = 2'h0;
  localparam logic [1:0] MATCH_FIRST = 2'h1;
  localparam logic [1:0] MATCH_SECOND = 2'h2;
  localparam logic [1:0] MATCH_BOTH = 2'h3;
  localparam logic [1:0] SHORT_TWO = 2'h0;
  localparam logic [1:0] SHORT_THREE = 2'h1;
  localparam logic [3:0] LEN_TWO = 4'h2;
  localparam logic [3:0] LEN_THREE = 4'h3;
  localparam logic [3:0] LEN_FOUR = 4'h4;
  localparam logic [1:0] OUT_RESET = 2'h3;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [7:0] byte1;
    logic [7:0] byte2;
    logic [7:0] byte3;
    logic [3:0] entry_count;
    logic [12*8-1:0] entries;
  } command_word_type;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [7:0] index;
    logic [7:0] pins;
    logic [15:0] value;
  } status_word_type;

  typedef struct packed {
    logic [1:0] address_match;
    logic [1:0] short_select;
    logic [1:0] input_change_report_select;
    logic [3:0] address_entry_count;
    logic [12*8-1:0] address_table_entries;
  } mode_type;

  typedef enum logic [1:0] {
    IDLE = 2'b00,
    DUMP = 2'b01
  } state_type;

  typedef struct packed {
    state_type state;
    logic [1:0] gp_output;
    logic [1:0] in_sample;
    logic [1:0] out_sample;
    logic [31:0] tick;
    logic [7:0] dump_index;
    mode_type mode;
    status_word_type status;
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic address_match_hit;
    logic short_flag;
  } handler_state_type;
endpackage : aux_cmd_pkg

// [tb/aux_host_model.sv]
// host model: hands over command words and takes status words
// assumes the handler takes commands on the rising edge of clk_in
`timescale 1ns/100ps
module aux_host_model import aux_cmd_pkg::*; (
  input wire logic clk_in,
  input wire logic command_ready_in,
  input wire status_word_type status_word_in,
  output command_word_type command_word_out,
  output logic status_ready_out
);
  int stall = 0;
  initial begin
    command_word_out = '0;
    status_ready_out = 1'b0;
  end
  task automatic send(input logic [7:0] code, input logic [7:0] b1, input logic [7:0] b2,
      input logic [7:0] b3, input logic [3:0] cnt, input logic [95:0] ent);
    command_word_type released;
    @(negedge clk_in);
    command_word_out = {1'b1, code, b1, b2, b3, cnt, ent};
    do @(posedge clk_in); while (command_ready_in !== 1'b1);
    @(negedge clk_in);
    // released fields must not keep showing the old command
    released = ~command_word_out;
    released.valid = 1'b0;
    command_word_out = released;
  endtask : send
  task automatic take(output status_word_type s);
    int n;
    n = 0;
    while (status_word_in.valid !== 1'b1 && n < 50) begin
      @(negedge clk_in);
      n++;
    end
    // slow host: status must stand while ready is low
    repeat (stall) @(negedge clk_in);
    status_ready_out = 1'b1;
    @(posedge clk_in);
    s = status_word_in;
    @(negedge clk_in);
    status_ready_out = 1'b0;
  endtask : take
endmodule : aux_host_model

// [tb/test_hdlc_aux_command_handler.sv]
// self-checking bench for the auxiliary command handler
// assumes the host model above and a short sampling period
`timescale 1ns/100ps
module test_hdlc_aux_command_handler import aux_cmd_pkg::*; ;
  logic clk_in, reset_in, sr, cr, gi1, gi2, go1, go2, chk, hit, shrt;
  command_word_type cw;
  status_word_type sw, s;
  logic [NUM_STATS*16-1:0] stats;
  logic [7:0] a1, a2;
  logic [15:0] len;
  mode_type mode;
  int errors = 0;
  int total_checks = 0;
  hdlc_aux_command_handler #(.SAMPLE_PERIOD(16)) hdlc_aux_command_handler_i (
    .clk_in(clk_in), .reset_in(reset_in), .command_word_in(cw), .command_ready_out(cr),
    .status_word_out(sw), .status_ready_in(sr), .gp_input_one_in(gi1),
    .gp_input_two_in(gi2), .gp_output_one_out(go1), .gp_output_two_out(go2),
    .stats_counters_in(stats), .addr_check_in(chk), .rx_addr_first_in(a1),
    .rx_addr_second_in(a2), .rx_frame_length_in(len), .mode_out(mode),
    .address_match_out(hit), .short_frame_out(shrt));
  aux_host_model aux_host_model_i (.clk_in(clk_in), .command_ready_in(cr),
    .status_word_in(sw), .command_word_out(cw), .status_ready_out(sr));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict;
    if (errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  task automatic addr(input logic [7:0] f, input logic [7:0] sb, input logic [15:0] l,
      input logic eh, input logic es);
    @(negedge clk_in);
    a1 = f;
    a2 = sb;
    len = l;
    chk = 1'b1;
    @(negedge clk_in);
    chk = 1'b0;
    @(negedge clk_in);
    check(hit, eh);
    check(shrt, es);
  endtask : addr
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_pins;
    check({go2, go1}, 2'h3);
    check(sw.valid, 1'b0);
    for (int v = 0; v < 4; v++) begin
      aux_host_model_i.send(CMD_OUT_WRITE, 8'h00, {5'h00, v[1], 1'b0, v[0]}, 8'h00, 4'h0, '0);
      repeat (2) @(negedge clk_in);
      check({go2, go1}, v[1:0]);
    end
    gi1 = 1'b1;
    gi2 = 1'b0;
    repeat (40) @(negedge clk_in);
    aux_host_model_i.send(CMD_PIN_READ, 8'h00, 8'h00, 8'h00, 4'h0, '0);
    aux_host_model_i.take(s);
    check({s.valid, s.code}, {1'b1, STS_PIN_ACK});
    check(s.pins, 8'h0D);
    aux_host_model_i.send(CMD_PIN_READ_ALT, 8'h00, 8'h00, 8'h00, 4'h0, '0);
    aux_host_model_i.take(s);
    check(s.code, STS_PIN_ACK_ALT);
    aux_host_model_i.send(CMD_PIN_READ_ALT, 8'h01, 8'h00, 8'h00, 4'h0, '0);
    aux_host_model_i.take(s);
    check(s.code, STS_ILLEGAL);
    // an undefined code must be answered as illegal, not ignored
    aux_host_model_i.send(8'h50, 8'h00, 8'h00, 8'h00, 4'h0, '0);
    aux_host_model_i.take(s);
    check(s.code, STS_ILLEGAL);
  endtask : t_pins
  task automatic t_stats;
    aux_host_model_i.stall = 2;
    for (int n = 0; n < NUM_STATS; n++) begin
      aux_host_model_i.send(CMD_STATS_READ_ALT, 8'h00, n[7:0], 8'h00, 4'h0, '0);
      aux_host_model_i.take(s);
      check({s.code, s.index, s.value}, {STS_STATS_ACK, n[7:0], 16'hC000 + n[15:0]});
    end
    aux_host_model_i.send(CMD_STATS_READ_ALT, 8'h00, 8'h0B, 8'h00, 4'h0, '0);
    aux_host_model_i.take(s);
    check(s.code, STS_ILLEGAL);
    aux_host_model_i.send(CMD_STATS_READ_ALT, 8'h00, 8'h00, SEL_ALL, 4'h0, '0);
    for (int n = 0; n < NUM_STATS; n++) begin
      aux_host_model_i.take(s);
      check({s.code, s.index, s.value}, {STS_STATS_ACK, n[7:0], 16'hC000 + n[15:0]});
    end
    @(negedge clk_in);
    check({sw.valid, cr}, 2'h1);
    aux_host_model_i.stall = 0;
  endtask : t_stats
  task automatic t_match;
    // even count with a broadcast entry in the second pair
    aux_host_model_i.send(CMD_ADDR_UPDATE, 8'h00, 8'h00, 8'h00, 4'h4,
      {64'h0, 32'h56FF3412});
    for (int m = 0; m < 4; m++) begin
      aux_host_model_i.send(CMD_MODE_UPDATE, 8'h00, {2'h0, m[1:0], m[1:0], m[1:0]}, 8'h00,
        4'h0, '0);
      repeat (2) @(negedge clk_in);
      check({mode.input_change_report_select, mode.address_match, mode.short_select},
        {m[1:0], m[1:0], m[1:0]});
      check(mode.address_entry_count, 4'h4);
      check(mode.address_table_entries[31:0], 32'h56FF3412);
      check({go2, go1}, 2'h3);
      // code 11 is undefined and behaves as the four-byte limit
      addr(8'h77, 8'h77, {14'h0, m[1:0]} + 16'h1, m == 0, m != 3);
      addr(8'h12, 8'h34, {14'h0, m[1:0]} + 16'h2, 1'b1, 1'b0);
    end
    addr(8'hFF, 8'h56, 16'h0004, 1'b1, 1'b0);
    addr(8'h34, 8'hFF, 16'h0004, 1'b0, 1'b0);
    addr(8'h12, 8'h56, 16'h0004, 1'b0, 1'b0);
    aux_host_model_i.send(CMD_MODE_UPDATE, 8'h00, 8'h01, 8'h00, 4'h0, '0);
    addr(8'hFF, 8'h00, 16'h0004, 1'b1, 1'b0);
    addr(8'h56, 8'h00, 16'h0004, 1'b1, 1'b0);
    addr(8'h34, 8'h12, 16'h0004, 1'b1, 1'b0);
    addr(8'h00, 8'h12, 16'h0004, 1'b0, 1'b0);
    aux_host_model_i.send(CMD_MODE_UPDATE, 8'h00, 8'h02, 8'h00, 4'h0, '0);
    addr(8'h12, 8'h00, 16'h0004, 1'b0, 1'b0);
    addr(8'h00, 8'hFF, 16'h0004, 1'b1, 1'b0);
  endtask : t_match
  // ----------------------------------------
  // run
  // ----------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  initial begin
    reset_in = 1'b1;
    {gi1, gi2, chk, a1, a2, len} = '0;
    for (int n = 0; n < NUM_STATS; n++) stats[n*16+:16] = 16'hC000 + n[15:0];
    repeat (16) @(negedge clk_in);
    reset_in = 1'b0;
    t_pins();
    t_stats();
    t_match();
    print_verdict();
  end
  initial begin
    #400000;
    errors++;
    print_verdict();
  end
endmodule : test_hdlc_aux_command_handler
